// ===== verilog/pmbc_defs.vh
// Constants for the power-mode and boot control block: register offsets,
// field positions, reset values and timing counts.
// Assumes inclusion by bare name from the design file.
`ifndef PMBC_DEFS_VH
`define PMBC_DEFS_VH
// ****************************************
// Register byte offsets
// ****************************************
`define PMBC_CTRL_OFF 12'h000
`define PMBC_STAT_OFF 12'h004
`define PMBC_EVMASK_OFF 12'h008
`define PMBC_EVRISE_OFF 12'h00c
`define PMBC_EVFALL_OFF 12'h010
`define PMBC_EVPEND_OFF 12'h014
// ****************************************
// Control register fields
// ****************************************
`define PMBC_CTRL_DET_EN 0
`define PMBC_CTRL_DET_FALL 1
`define PMBC_CTRL_DET_RISE 2
`define PMBC_CTRL_STOP_LP 3
`define PMBC_CTRL_DEEP 4
`define PMBC_CTRL_RESET 32'h0000_0000
// ****************************************
// Status register fields
// ****************************************
`define PMBC_STAT_BOOT_LO 0
`define PMBC_STAT_BOOT_HI 1
`define PMBC_STAT_DET_OUT 2
`define PMBC_STAT_DET_FLAG 3
`define PMBC_STAT_STATE_LO 4
`define PMBC_STAT_STATE_HI 8
// ****************************************
// Boot selections
// ****************************************
`define PMBC_BOOT_FLASH 2'b00
`define PMBC_BOOT_SYSMEM 2'b01
`define PMBC_BOOT_SRAM 2'b10
// ****************************************
// Regulator modes
// ****************************************
`define PMBC_REG_MAIN 2'b00
`define PMBC_REG_LOWPWR 2'b01
`define PMBC_REG_OFF 2'b10
// ****************************************
// Timing: oscillator settle wait on Stop wakeup
// ****************************************
`define PMBC_OSC_SETTLE_NS 2000
`define PMBC_CLK_PERIOD_NS 25
`define PMBC_OSC_SETTLE_CYC ((`PMBC_OSC_SETTLE_NS + `PMBC_CLK_PERIOD_NS - 1) / `PMBC_CLK_PERIOD_NS)
`endif

// ===== verilog/pmbc_power_mode_and_boot_control.v
// Power-mode and boot control: boot pin capture, supply reset hold, voltage
// detector events, regulator mode, Sleep/Stop/Standby sequencing, event lines.
// Assumes an AHB-Lite master, a core giving sleep requests, and analog
// comparator levels synchronous to hclk.
// Operation
// RULE_01 - Boot pins sampled at startup select flash, system memory or SRAM.
// RULE_02 - Supply reset is always active; no setting can disable it.
// RULE_03 - Internal reset held while supply is below the reset threshold.
// RULE_04 - Detector interrupt on falling, rising or both threshold crossings.
// RULE_05 - Voltage detector inactive until software enables it.
// RULE_06 - Regulator: main in Run, low-power in Stop, off in Standby.
// RULE_07 - Regulator enabled in normal mode after any reset.
// RULE_08 - Sleep halts only the processor clock; peripherals keep running.
// RULE_09 - Any peripheral interrupt or event wakes from Sleep.
// RULE_10 - Stop gates core clocks and disables PLL and both fast oscillators.
// RULE_11 - Stop keeps SRAM and register contents.
// RULE_12 - Stop uses main or low-power regulator per software setting.
// RULE_13 - Any external event line wakes from Stop.
// RULE_14 - Standby switches regulator, PLL and fast oscillators off.
// RULE_15 - Standby loses core contents except backup and standby circuitry.
// RULE_16 - Standby exits only on reset pin, watchdog reset, wake pin, alarm.
// RULE_17 - Low-power modes never stop calendar, watchdog or their clocks.
// RULE_18 - Each event line has own edge selection and mask.
// RULE_19 - Core requests low power with entry and Stop/Standby selection.
// RULE_20 - Stop wakeup re-enables oscillator and main regulator before clock.
//
// The AHB-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "pmbc_defs.vh"
`default_nettype none
module pmbc_power_mode_and_boot_control #(
  parameter NLINES = 16,
  parameter SETTLE_CYC = `PMBC_OSC_SETTLE_CYC
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  input wire [1:0] boot_pins,
  output reg [1:0] boot_select,
  input wire supply_below_reset_thr,
  input wire external_reset_pin_n,
  input wire independent_watchdog_rst,
  input wire wakeup_pin,
  input wire calendar_alarm,
  input wire usb_wakeup,
  input wire supply_below_det_thr,
  output reg programmable_voltage_detector_irq,
  input wire [NLINES-1:0] external_event_lines,
  input wire periph_irq,
  input wire sleep_entry,
  input wire sleep_deep,
  output wire system_reset_n,
  output reg cpu_clk_en,
  output reg core_clk_en,
  output reg pll_en,
  output reg internal_high_speed_osc_en,
  output reg external_high_speed_osc_en,
  output reg [1:0] regulator_mode,
  output reg core_retain,
  output wire backup_clk_en,
  output reg wake_irq
);
  // ****************************************
  // States
  // ****************************************
  localparam [4:0] ST_RUN = 5'b00001;
  localparam [4:0] ST_SLEEP = 5'b00010;
  localparam [4:0] ST_STOP = 5'b00100;
  localparam [4:0] ST_WAKE = 5'b01000;
  localparam [4:0] ST_STBY = 5'b10000;
  reg [4:0] state_reg;
  reg [15:0] settle_reg;
  reg [31:0] ctrl_reg;
  reg [NLINES-1:0] mask_reg;
  reg [NLINES-1:0] rise_reg;
  reg [NLINES-1:0] fall_reg;
  reg [NLINES+2:0] pend_reg;
  reg [NLINES-1:0] lines_q_reg;
  reg det_q_reg;
  reg det_flag_reg;
  reg wkpin_q_reg;
  reg boot_taken_reg;
  reg stby_rst_reg;
  reg ph_wr_reg;
  reg ph_rd_reg;
  reg [11:0] ph_addr_reg;
  // ****************************************
  // Supply reset
  // ****************************************
  // RULE_02 no enable term
  // RULE_03 reset follows supply level
  // RULE_15 Standby exit runs a full core reset
  assign system_reset_n = hresetn & ~supply_below_reset_thr & ~stby_rst_reg;
  // RULE_17 backup clocks never gated
  assign backup_clk_en = 1'b1;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  // ****************************************
  // Event detection
  // ****************************************
  wire det_on = ctrl_reg[`PMBC_CTRL_DET_EN];
  wire det_rise = det_on & det_q_reg & ~supply_below_det_thr;
  wire det_fall = det_on & ~det_q_reg & supply_below_det_thr;
  // RULE_04 edge selection on detector
  wire det_evt = (det_fall & ctrl_reg[`PMBC_CTRL_DET_FALL]) |
    (det_rise & ctrl_reg[`PMBC_CTRL_DET_RISE]);
  // RULE_18 per-line edge and mask
  wire [NLINES-1:0] line_evt = mask_reg &
    ((rise_reg & external_event_lines & ~lines_q_reg) |
    (fall_reg & ~external_event_lines & lines_q_reg));
  wire [NLINES+2:0] new_evt = {usb_wakeup, calendar_alarm, det_evt, line_evt};
  wire wk_rise = wakeup_pin & ~wkpin_q_reg;
  // ****************************************
  // Bus address phase capture
  // ****************************************
  wire ph_go = hsel & hready & htrans[1];
  wire wr_ctrl = ph_wr_reg & (ph_addr_reg == `PMBC_CTRL_OFF);
  wire wr_mask = ph_wr_reg & (ph_addr_reg == `PMBC_EVMASK_OFF);
  wire wr_rise = ph_wr_reg & (ph_addr_reg == `PMBC_EVRISE_OFF);
  wire wr_fall = ph_wr_reg & (ph_addr_reg == `PMBC_EVFALL_OFF);
  wire wr_pend = ph_wr_reg & (ph_addr_reg == `PMBC_EVPEND_OFF);
  wire wr_stat = ph_wr_reg & (ph_addr_reg == `PMBC_STAT_OFF);
  // Pipelined address phase
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ph_wr_reg <= 1'b0;
      ph_rd_reg <= 1'b0;
      ph_addr_reg <= 12'h000;
    end
    else
    begin
      ph_wr_reg <= ph_go & hwrite;
      ph_rd_reg <= ph_go & ~hwrite;
      ph_addr_reg <= {haddr[11:2], 2'b00};
    end
  end
  // Read data, registered at the address phase so it stands in data phase
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (ph_go & ~hwrite)
    begin
      case ({haddr[11:2], 2'b00})
        `PMBC_CTRL_OFF: hrdata <= ctrl_reg;
        `PMBC_STAT_OFF: hrdata <= {23'h000000, state_reg, det_flag_reg,
          supply_below_det_thr & det_on, boot_select};
        `PMBC_EVMASK_OFF: hrdata <= {{(32-NLINES){1'b0}}, mask_reg};
        `PMBC_EVRISE_OFF: hrdata <= {{(32-NLINES){1'b0}}, rise_reg};
        `PMBC_EVFALL_OFF: hrdata <= {{(32-NLINES){1'b0}}, fall_reg};
        `PMBC_EVPEND_OFF: hrdata <= {{(29-NLINES){1'b0}}, pend_reg};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end
  // ****************************************
  // Software registers
  // ****************************************
  // RULE_05 detector off at reset
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_reg <= `PMBC_CTRL_RESET;
      mask_reg <= {NLINES{1'b0}};
      rise_reg <= {NLINES{1'b0}};
      fall_reg <= {NLINES{1'b0}};
    end
    else if (stby_rst_reg)
    begin
      ctrl_reg <= `PMBC_CTRL_RESET;
      mask_reg <= {NLINES{1'b0}};
      rise_reg <= {NLINES{1'b0}};
      fall_reg <= {NLINES{1'b0}};
    end
    else
    begin
      if (wr_ctrl)
        ctrl_reg <= {27'h0000000, hwdata[4:0]};
      if (wr_mask)
        mask_reg <= hwdata[NLINES-1:0];
      if (wr_rise)
        rise_reg <= hwdata[NLINES-1:0];
      if (wr_fall)
        fall_reg <= hwdata[NLINES-1:0];
    end
  end
  // Sticky flags; a new event beats a write-one clear
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pend_reg <= {(NLINES+3){1'b0}};
      det_flag_reg <= 1'b0;
      lines_q_reg <= {NLINES{1'b0}};
      det_q_reg <= 1'b0;
      wkpin_q_reg <= 1'b0;
      programmable_voltage_detector_irq <= 1'b0;
    end
    else
    begin
      pend_reg <= (pend_reg & ~(wr_pend ? hwdata[NLINES+2:0] : {(NLINES+3){1'b0}}))
        | new_evt;
      det_flag_reg <= (det_flag_reg & ~(wr_stat & hwdata[`PMBC_STAT_DET_FLAG])) | det_evt;
      lines_q_reg <= external_event_lines;
      det_q_reg <= supply_below_det_thr;
      wkpin_q_reg <= wakeup_pin;
      // RULE_04 interrupt while flag stands
      programmable_voltage_detector_irq <= det_flag_reg | det_evt;
    end
  end
  // ****************************************
  // Boot capture
  // ****************************************
  // RULE_01 capture once after reset release and again on Standby exit
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      boot_taken_reg <= 1'b0;
      boot_select <= `PMBC_BOOT_FLASH;
    end
    else if (!boot_taken_reg || stby_rst_reg)
    begin
      boot_taken_reg <= ~stby_rst_reg;
      case (boot_pins)
        2'b01: boot_select <= `PMBC_BOOT_SYSMEM;
        2'b11: boot_select <= `PMBC_BOOT_SRAM;
        default: boot_select <= `PMBC_BOOT_FLASH;
      endcase
    end
  end
  // ****************************************
  // Power mode sequencer
  // ****************************************
  // RULE_19 request from the core
  wire want_stby = sleep_entry & sleep_deep & ctrl_reg[`PMBC_CTRL_DEEP];
  wire want_stop = sleep_entry & sleep_deep & ~ctrl_reg[`PMBC_CTRL_DEEP];
  // RULE_16 standby exit sources
  wire stby_exit = ~external_reset_pin_n | independent_watchdog_rst | wk_rise |
    calendar_alarm;
  // RULE_13 any unmasked event line with its edge selected wakes Stop
  wire stop_wake = |new_evt;
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg <= ST_RUN;
      settle_reg <= 16'h0000;
      stby_rst_reg <= 1'b0;
      wake_irq <= 1'b0;
    end
    else
    begin
      stby_rst_reg <= 1'b0;
      wake_irq <= 1'b0;
      case (state_reg)
        ST_RUN:
        begin
          if (want_stby)
            state_reg <= ST_STBY;
          else if (want_stop)
            state_reg <= ST_STOP;
          else if (sleep_entry)
            state_reg <= ST_SLEEP;
        end
        ST_SLEEP:
        begin
          // RULE_09 any interrupt or event
          if (periph_irq | stop_wake)
          begin
            state_reg <= ST_RUN;
            wake_irq <= 1'b1;
          end
        end
        ST_STOP:
        begin
          if (stop_wake)
          begin
            state_reg <= ST_WAKE;
            settle_reg <= SETTLE_CYC[15:0];
          end
        end
        ST_WAKE:
        begin
          // RULE_20 settle before clock release
          if (settle_reg <= 16'h0001)
          begin
            state_reg <= ST_RUN;
            wake_irq <= 1'b1;
          end
          else
            settle_reg <= settle_reg - 16'h0001;
        end
        ST_STBY:
        begin
          if (stby_exit)
          begin
            state_reg <= ST_RUN;
            stby_rst_reg <= 1'b1;
          end
        end
        default: state_reg <= ST_RUN;
      endcase
    end
  end
  // ****************************************
  // Clock and regulator outputs
  // ****************************************
  // Registered from state so outputs never glitch
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cpu_clk_en <= 1'b1;
      core_clk_en <= 1'b1;
      pll_en <= 1'b1;
      internal_high_speed_osc_en <= 1'b1;
      external_high_speed_osc_en <= 1'b1;
      // RULE_07 main regulator after reset
      regulator_mode <= `PMBC_REG_MAIN;
      core_retain <= 1'b1;
    end
    else
    begin
      // RULE_08 only cpu clock off in Sleep
      cpu_clk_en <= (state_reg == ST_RUN);
      // RULE_10 core clocks and oscillators off in Stop
      // RULE_14 and in Standby
      core_clk_en <= (state_reg == ST_RUN) | (state_reg == ST_SLEEP);
      pll_en <= (state_reg == ST_RUN) | (state_reg == ST_SLEEP);
      internal_high_speed_osc_en <= ~((state_reg == ST_STOP) | (state_reg == ST_STBY));
      external_high_speed_osc_en <= (state_reg == ST_RUN) | (state_reg == ST_SLEEP);
      // RULE_06 regulator per mode
      // RULE_12 low-power regulator only if selected
      if (state_reg == ST_STBY)
        regulator_mode <= `PMBC_REG_OFF;
      else if ((state_reg == ST_STOP) & ctrl_reg[`PMBC_CTRL_STOP_LP])
        regulator_mode <= `PMBC_REG_LOWPWR;
      else
        regulator_mode <= `PMBC_REG_MAIN;
      // RULE_11 retention in Stop
      // RULE_15 lost in Standby
      core_retain <= (state_reg != ST_STBY);
    end
  end
endmodule // pmbc_power_mode_and_boot_control
`default_nettype wire

// ===== tb/pmbc_core_model.sv
// Behavioural processor core that issues low-power requests.
// Assumes one hclk domain; go is a one-cycle command from the bench.
`timescale 1ns/1ps
`default_nettype none
module pmbc_core_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic go,
  input wire logic deep,
  input wire logic cpu_clk_en,
  output var logic sleep_entry,
  output var logic sleep_deep
);
  // entry with selection
  // Held until the clock stops, then dropped so wake does not re-enter;
  // released selection is inverted so no stale level is relied on
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      {sleep_entry, sleep_deep} <= 2'h0;
    else if (go)
      {sleep_entry, sleep_deep} <= {1'h1, deep};
    else if (sleep_entry && !cpu_clk_en)
      {sleep_entry, sleep_deep} <= {1'h0, ~sleep_deep};
  end
endmodule // pmbc_core_model
`default_nettype wire

// ===== tb/pmbc_checker.sv
// Port-level assertions for the power-mode and boot control block.
// Bound to the top module; single hclk domain.
`timescale 1ns/1ps
`default_nettype none
module pmbc_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [1:0] boot_pins,
  input wire logic [1:0] boot_select,
  input wire logic supply_below_reset_thr,
  input wire logic system_reset_n,
  input wire logic backup_clk_en,
  input wire logic cpu_clk_en,
  input wire logic core_clk_en,
  input wire logic pll_en,
  input wire logic internal_high_speed_osc_en,
  input wire logic external_high_speed_osc_en,
  input wire logic [1:0] regulator_mode,
  input wire logic core_retain,
  input wire logic sleep_entry,
  input wire logic wake_irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Deep entry gates the core clocks
  sequence s_core_gated;
    $fell(core_clk_en);
  endsequence
  // Processor clock released after wake
  sequence s_cpu_back;
    $rose(cpu_clk_en);
  endsequence
  chk_boot_map:
    assert property ($rose(hresetn) |=> boot_select ==
      (boot_pins == 2'h1 ? 2'h1 : boot_pins == 2'h3 ? 2'h2 : 2'h0))
    else $error("boot select wrong");
  chk_reset_main:
    assert property ($rose(hresetn) |-> regulator_mode == 2'h0 && internal_high_speed_osc_en)
    else $error("regulator not main after reset");
  chk_supply_hold:
    assert property (supply_below_reset_thr |-> !system_reset_n)
    else $error("reset not held on low supply");
  chk_backup_clk:
    assert property (backup_clk_en)
    else $error("backup clock stopped");
  chk_stop_gating:
    assert property (s_core_gated |-> !pll_en && !internal_high_speed_osc_en
      && !external_high_speed_osc_en)
    else $error("oscillators left on");
  chk_standby_off:
    assert property (!core_retain |-> regulator_mode == 2'h2 && !pll_en && !core_clk_en)
    else $error("standby not powered down");
  chk_wake_order:
    assert property (s_cpu_back |-> internal_high_speed_osc_en && regulator_mode == 2'h0)
    else $error("clock released before oscillator");
  chk_req_first:
    assert property ($fell(cpu_clk_en) |-> $past(sleep_entry))
    else $error("low power without request");
  chk_wake_pulse:
    assert property (wake_irq |=> !wake_irq)
    else $error("wake pulse too long");
  // Sleep or Stop wake must announce itself before the clock returns
  chk_wake_flag:
    assert property ($rose(cpu_clk_en) && $past(core_retain) |-> $past(wake_irq))
    else $error("clock released without wake pulse");
  // Standby exit must pass through a core reset pulse
  chk_standby_reset:
    assert property ($rose(core_retain) |-> !$past(system_reset_n))
    else $error("standby exit without core reset");
endmodule // pmbc_checker
bind pmbc_power_mode_and_boot_control pmbc_checker pmbc_checker_inst (.hclk, .hresetn,
  .boot_pins, .boot_select, .supply_below_reset_thr, .system_reset_n, .backup_clk_en,
  .cpu_clk_en, .core_clk_en, .pll_en, .internal_high_speed_osc_en,
  .external_high_speed_osc_en, .regulator_mode, .core_retain, .sleep_entry, .wake_irq);
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench: AHB-Lite register access, mode table, detector and events.
// Assumes the core model drives the sleep request pins.
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct packed {logic [4:0] ctrl; logic deep; logic [6:0] wk; logic [4:0] exp;} pmbc_row_t;
  // Mode rows: control, deep, wake source, {regulator, pll, core clk, retain}
  pmbc_row_t rows [8] = '{'{5'h00, 1'h0, 7'h01, 5'h07}, '{5'h00, 1'h1, 7'h02, 5'h01},
    '{5'h08, 1'h1, 7'h08, 5'h09}, '{5'h08, 1'h1, 7'h04, 5'h09}, '{5'h10, 1'h1, 7'h10, 5'h10},
    '{5'h10, 1'h1, 7'h20, 5'h10}, '{5'h10, 1'h1, 7'h40, 5'h10}, '{5'h10, 1'h0, 7'h01, 5'h07}};
  logic [3:0] boots [4] = '{4'he, 4'h5, 4'h0, 4'h8};
  logic [31:0] dets [4] = '{32'h6, 32'h3, 32'h5, 32'h7};
  pmbc_row_t r;
  logic hclk, hresetn = 1'h0, hwrite = 1'h0, go = 1'h0, deep = 1'h0;
  logic supply_below_reset_thr = 1'h0, supply_below_det_thr = 1'h0;
  logic [1:0] htrans = 2'h0, boot_pins = 2'h0;
  logic [6:0] wk = 7'h00;
  logic [11:0] haddr = 12'h000;
  logic [15:0] ev = 16'h0000;
  logic [31:0] hwdata = 32'h0, q;
  wire [31:0] hrdata;
  wire [1:0] boot_select, regulator_mode;
  wire hreadyout, hresp, system_reset_n, cpu_clk_en, core_clk_en, pll_en, core_retain;
  wire internal_high_speed_osc_en, external_high_speed_osc_en, sleep_entry, sleep_deep;
  wire programmable_voltage_detector_irq;
  int n_errors = 0, samples_checked = 0, cyc = 0;
  pmbc_power_mode_and_boot_control #(.NLINES(16), .SETTLE_CYC(4))
    pmbc_power_mode_and_boot_control_inst (.hclk, .hresetn, .hsel(1'h1), .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .boot_pins, .boot_select, .supply_below_reset_thr, .external_reset_pin_n(~wk[6]),
    .independent_watchdog_rst(wk[5]), .wakeup_pin(wk[4]), .calendar_alarm(wk[3]),
    .usb_wakeup(wk[2]), .supply_below_det_thr, .programmable_voltage_detector_irq,
    .external_event_lines(ev | {15'h0, wk[1]}), .periph_irq(wk[0]), .sleep_entry,
    .sleep_deep, .system_reset_n, .cpu_clk_en, .core_clk_en, .pll_en,
    .internal_high_speed_osc_en, .external_high_speed_osc_en, .regulator_mode,
    .core_retain, .backup_clk_en(), .wake_irq());
  pmbc_core_model pmbc_core_model_inst (.hclk, .hresetn, .go, .deep, .cpu_clk_en,
    .sleep_entry, .sleep_deep);
  // Free-running clock, 25 ns
  initial
  begin
    hclk = 1'h0;
    forever #12.5 hclk = ~hclk;
  end
  // Hang guard, far above the expected run length
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      end_of_test();
    end
  end
  task automatic end_of_test;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Single word transfer; waits on hready in both phases
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    q = hrdata;
  endtask
  task automatic wait_cpu(input logic v);
    int k;
    k = 0;
    while (cpu_clk_en !== v && k < 100)
    begin
      tick(1);
      k++;
    end
    chk("cpu_clk_en", {31'h0, v}, {31'h0, cpu_clk_en});
  endtask
  // Main sequence: resets, mode table, then awkward cases
  initial
  begin
    for (int i = 0; i < 4; i++)
    begin
      boot_pins <= boots[i][3:2];
      hresetn <= 1'h0;
      tick(5);
      hresetn <= 1'h1;
      tick(2);
      chk("boot", {30'h0, boots[i][1:0]}, {30'h0, boot_select});
      chk("rst_reg", 32'h1, {29'h0, regulator_mode, internal_high_speed_osc_en});
    end
    for (int i = 0; i < 8; i++)
    begin
      r = rows[i];
      bus(1'h1, 12'h014, 32'h7ffff);
      bus(1'h1, 12'h008, 32'h1);
      bus(1'h1, 12'h00c, 32'h1);
      bus(1'h1, 12'h000, {27'h0, r.ctrl});
      go <= 1'h1;
      deep <= r.deep;
      tick(1);
      go <= 1'h0;
      wait_cpu(1'h0);
      tick(3);
      chk("mode", {27'h0, r.exp}, {27'h0, regulator_mode, pll_en, core_clk_en, core_retain});
      wk <= r.wk;
      tick(2);
      wk <= 7'h00;
      wait_cpu(1'h1);
      chk("wake", 32'h1, {29'h0, regulator_mode, internal_high_speed_osc_en});
      bus(1'h0, 12'h000, 32'h0);
      chk("ctrl", r.exp == 5'h10 ? 32'h0 : {27'h0, r.ctrl}, q);
    end
    for (int i = 0; i < 4; i++)
    begin
      bus(1'h1, 12'h000, dets[i]);
      supply_below_det_thr <= 1'h1;
      tick(3);
      bus(1'h0, 12'h004, 32'h0);
      chk("det_fall", {30'h0, {2{dets[i][0] & dets[i][1]}}}, {30'h0, q[3], programmable_voltage_detector_irq});
      bus(1'h1, 12'h004, 32'h8);
      supply_below_det_thr <= 1'h0;
      tick(3);
      bus(1'h0, 12'h004, 32'h0);
      chk("det_rise", {30'h0, {2{dets[i][0] & dets[i][2]}}}, {30'h0, q[3], programmable_voltage_detector_irq});
      bus(1'h1, 12'h004, 32'h8);
    end
    bus(1'h1, 12'h008, 32'h4);
    bus(1'h1, 12'h00c, 32'h0);
    bus(1'h1, 12'h010, 32'h6);
    bus(1'h1, 12'h014, 32'h7ffff);
    ev <= 16'h0006;
    tick(3);
    ev <= 16'h0000;
    tick(3);
    bus(1'h0, 12'h014, 32'h0);
    chk("pending", 32'h4, q);
    bus(1'h0, 12'h100, 32'h0);
    chk("unmapped", 32'h0, q);
    chk("hresp", 32'h0, {31'h0, hresp});
    supply_below_reset_thr <= 1'h1;
    tick(1);
    chk("sys_reset", 32'h0, {31'h0, system_reset_n});
    supply_below_reset_thr <= 1'h0;
    tick(2);
    end_of_test();
  end
endmodule // tb
`default_nettype wire
